// [bench/ref_reset_source.sv]
// reference oscillator and external reset source model
`timescale 1ns/100ps
module ref_reset_source
(
	input wire logic hold_req,
	input wire logic [1:0] ratio_req,
	output logic reference_clock_in,
	output logic ext_reset_n,
	output logic [1:0] ratio_cfg
);
	int low_cnt = 0;
	// free-running, so it is valid long before any release
	initial reference_clock_in = 1'b0;
	initial ext_reset_n = 1'b0;
	initial ratio_cfg = 2'h0;
	always #200 reference_clock_in = ~reference_clock_in;
	// pin moves well ahead of the low phase, so setup is always met
	always @(posedge reference_clock_in)
	begin
		low_cnt <= ext_reset_n ? 0 : low_cnt + 1;
		if (hold_req)
		begin
			ext_reset_n <= #60 1'b0;
			ratio_cfg <= ratio_req;
		end
		else if (low_cnt >= 4)
			ext_reset_n <= #60 1'b1;
	end
endmodule

// [bench/testbench.sv]
// bench for the loop ratio and core reset release block
`timescale 1ns/100ps
module testbench
	import clk_ratio_pkg::*;
;
	typedef struct packed {logic [8:0] w; logic [3:0] div; logic [1:0] idiv;} row_t;
	row_t rows [4] = '{'{9'h005, 4'h1, 2'h1}, '{9'h14c, 4'h2, 2'h2},
		'{9'h08a, 4'h4, 2'h1}, '{9'h1d0, 4'h8, 2'h2}};
	logic [1:0] pin_sel [3] = '{2'h1, 2'h3, 2'h0};
	logic [MULT_W-1:0] pin_mult [3] = '{RATIO_MULT_1, RATIO_MULT_3, RATIO_MULT_0};
	logic clk = 0, sys_rst = 1, clk_en = 1, reg_write = 0, reg_read = 0, hold_req = 1;
	logic [1:0] ratio_req = 2'h2, ratio_cfg, loop_input_divisor;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, got;
	logic reference_clock_in, ext_reset_n, core_reset, periph_clk_en, prev;
	logic [MULT_W-1:0] eff_multiplier;
	logic [3:0] eff_post_divisor;
	logic [MULT_W:0] vco_ratio;
	logic [4:0] core_divisor;
	int num_errors = 0, total_checks = 0, cycles = 0, n;
	always #25 clk = ~clk;
	clk_ratio_ctrl #(.REF_DELAY(8)) u_dut (.clk, .sys_rst, .clk_en, .reference_clock_in,
		.ext_reset_n, .ratio_cfg, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
		.core_reset, .periph_clk_en, .eff_multiplier, .eff_post_divisor, .vco_ratio,
		.core_divisor, .loop_input_divisor);
	ref_reset_source u_src (.hold_req, .ratio_req, .reference_clock_in, .ext_reset_n,
		.ratio_cfg);
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e)
		begin
			num_errors++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk);
		reg_read <= 1'b0;
		#1 got = reg_rdata;
	endtask
	// 8 reference periods are 64 core cycles at these rates
	task automatic release_core();
		hold_req = 1'b0;
		@(posedge ext_reset_n);
		n = 0;
		while (core_reset !== 1'b0 && n < 200)
		begin
			@(posedge clk);
			n++;
		end
		#1;
		chk(n >= 66, 1);
		chk(n <= 81, 1);
	endtask
	initial
	begin
		cyc(11);
		chk(core_reset, 1);
		chk(periph_clk_en, 0);
		chk(eff_post_divisor, 1);
		chk(core_divisor, 2);
		chk(loop_input_divisor, 1);
		@(posedge clk) sys_rst <= 1'b0;
		cyc(30);
		chk(eff_multiplier, RATIO_MULT_2);
		rd(STAT_ADDR);
		chk(got, 32'h0002_4002);
		wr(CTRL_ADDR, 32'h0000_00c3);
		cyc(3);
		chk(eff_post_divisor, 1);
		release_core();
		cyc(2);
		chk(eff_post_divisor, 8);
		chk(eff_multiplier, RATIO_MULT_2);
		prev = periph_clk_en;
		repeat (4)
		begin
			cyc(1);
			chk(periph_clk_en, !prev);
			prev = periph_clk_en;
		end
		foreach (rows[i])
		begin
			wr(CTRL_ADDR, {23'h0, rows[i].w});
			cyc(3);
			chk(eff_multiplier, rows[i].w[5:0]);
			chk(vco_ratio, {rows[i].w[5:0], 1'b0});
			chk(eff_post_divisor, rows[i].div);
			chk(core_divisor, {rows[i].div, 1'b0});
			chk(loop_input_divisor, rows[i].idiv);
			rd(CTRL_ADDR);
			chk(got, {23'h0, rows[i].w});
			rd(STAT_ADDR);
			chk(got, {11'h0, rows[i].div, 2'h0, rows[i].w[5:0], 9'h001});
		end
		rd(8'h08);
		chk(got, 0);
		cyc(1);
		chk(reg_rdata, 0);
		clk_en <= 1'b0;
		prev = periph_clk_en;
		cyc(3);
		chk(periph_clk_en, prev);
		clk_en <= 1'b1;
		// every other ratio pin code through a full external reset
		foreach (pin_sel[j])
		begin
			hold_req = 1'b1;
			ratio_req = pin_sel[j];
			cyc(40);
			chk(core_reset, 1);
			chk(eff_post_divisor, 1);
			chk(eff_multiplier, pin_mult[j]);
			release_core();
		end
		report_and_stop();
	end
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			num_errors++;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
endmodule

// [include/clk_ratio_pkg.sv]
// constants for the loop ratio and core reset release block
package clk_ratio_pkg;
	localparam logic [7:0] CTRL_ADDR = 8'h00;
	localparam logic [7:0] STAT_ADDR = 8'h04;
	localparam int MULT_W = 6;
	localparam int MULT_LSB = 0;
	localparam int DIVSEL_LSB = 6;
	localparam int HALVE_BIT = 8;
	localparam int STAT_REL_BIT = 0;
	localparam int STAT_RST_BIT = 1;
	localparam int STAT_VCO_LSB = 8;
	localparam int STAT_CDIV_LSB = 16;
	localparam logic [1:0] DIVSEL_RST = 2'h0;
	localparam logic HALVE_RST = 1'b0;
	localparam int REF_DELAY_CYCLES = 4096;
	localparam int CORE_SYNC_CYCLES = 2;
	localparam int CNT_W = 13;
	// multipliers picked by the ratio pins while in reset, and the multiplier loaded by sys_rst
	localparam logic [MULT_W-1:0] RATIO_MULT_0 = 6'h08;
	localparam logic [MULT_W-1:0] RATIO_MULT_1 = 6'h10;
	localparam logic [MULT_W-1:0] RATIO_MULT_2 = 6'h20;
	localparam logic [MULT_W-1:0] RATIO_MULT_3 = 6'h10;
	localparam logic [MULT_W-1:0] MULT_RST = 6'h08;
endpackage

// [src/clk_ratio_ctrl.sv]
// loop ratio selection, peripheral clock enable and core reset release sequencer
// Behaviour
// [R1] the oscillator ratio reported is two times the effective multiplier over the loop input.
// [R2] the core divisor is two times the post divider, which is 1, 2, 4 or 8 from its field.
// [R3] while reset is active the post divider is forced to one.
// [R4] in reset the multiplier comes from the ratio pins, after reset from the control register.
// [R5] the input halving control makes the loop input the reference divided by two.
// [R6] the peripheral clock enable marks every second core clock, giving a two-period clock.
// [R7] with halving off software keeps reference times multiplier within half the oscillator max.
// [R8] with halving on software keeps reference times multiplier within the oscillator max.
// [R9] software reprogramming keeps the core clock period at or below 10 ns.
// [R10] core reset releases no earlier than 4096 reference cycles plus two core cycles.
// [R11] a missed setup window may add one reference cycle, never more than 4097 in total.
// [R12] later resets hold the reset pin low for at least four reference cycles.
// [R13] the ratio pins are stable 20 us before the reset pin is released.
// [R14] the reference clock is stable 10 us before the reset pin is released.
// [R15] at power-up the reset pin is held low up to 100 us while the loop locks.
// [R16] the core reset release is synchronised to the core clock after the counted delay.
`timescale 1ns/100ps
module clk_ratio_ctrl
	import clk_ratio_pkg::*;
#(
	parameter int REF_DELAY = REF_DELAY_CYCLES
)
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic reference_clock_in,
	input wire logic ext_reset_n,
	input wire logic [1:0] ratio_cfg,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [31:0] reg_rdata,
	output logic core_reset,
	output logic periph_clk_en,
	output logic [MULT_W-1:0] eff_multiplier,
	output logic [3:0] eff_post_divisor,
	output logic [MULT_W:0] vco_ratio,
	output logic [4:0] core_divisor,
	output logic [1:0] loop_input_divisor
);
	typedef enum logic [1:0] {HOLD, COUNT, SYNC, RUN} seq_t;

	function automatic logic [MULT_W-1:0] pin_multiplier(input logic [1:0] cfg);
		unique case (cfg)
			2'h0: pin_multiplier = RATIO_MULT_0;
			2'h1: pin_multiplier = RATIO_MULT_1;
			2'h2: pin_multiplier = RATIO_MULT_2;
			2'h3: pin_multiplier = RATIO_MULT_3;
		endcase
	endfunction

	function automatic logic [3:0] post_divisor(input logic [1:0] sel);
		post_divisor = 4'h1 << sel;
	endfunction

	// pin synchronisers: {cfg1, cfg0, reset_n, reference}
	logic [3:0] s1_q, s2_q, s3_q, pin_q;
	logic [3:0] pin_d;
	logic ref_rise;
	always_comb
	begin
		pin_d = pin_q;
		for (int i = 0; i < 4; i++)
		begin
			if (s2_q[i] == s3_q[i])
			begin
				pin_d[i] = s2_q[i];
			end
		end
		ref_rise = pin_d[0] & ~pin_q[0];
	end
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			s1_q <= 4'h0;
			s2_q <= 4'h0;
			s3_q <= 4'h0;
			pin_q <= 4'h0;
		end
		else if (clk_en)
		begin
			s1_q <= {ratio_cfg, ext_reset_n, reference_clock_in};
			s2_q <= s1_q;
			s3_q <= s2_q;
			pin_q <= pin_d;
		end
	end

	// release sequencer
	seq_t state_q, state_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic [1:0] sync_q, sync_d;
	always_comb
	begin
		state_d = state_q;
		cnt_d = cnt_q;
		sync_d = sync_q;
		if (!pin_q[1])
		begin
			state_d = HOLD;
			cnt_d = '0;
			sync_d = '0;
		end
		else
		begin
			unique case (state_q)
				HOLD:
				begin
					state_d = COUNT;
					cnt_d = '0;
				end
				COUNT:
				begin
					// counting on the filtered edge keeps the total within one extra cycle
					if (ref_rise) //[R10]
					begin
						cnt_d = cnt_q + CNT_W'(1);
						if (cnt_q == CNT_W'(REF_DELAY - 1)) //[R11]
						begin
							state_d = SYNC;
							sync_d = '0;
						end
					end
				end
				SYNC:
				begin
					sync_d = sync_q + 2'h1;
					if (sync_q == 2'(CORE_SYNC_CYCLES - 1)) //[R16]
					begin
						state_d = RUN;
					end
				end
				RUN:
				begin
					state_d = RUN;
				end
			endcase
		end
	end

	// control register and effective ratio
	logic [MULT_W-1:0] mult_q, mult_d;
	logic [1:0] divsel_q, divsel_d;
	logic halve_q, halve_d;
	logic in_rst;
	logic [MULT_W-1:0] mult_e;
	logic [3:0] pdiv_e;
	always_comb
	begin
		in_rst = (state_q != RUN);
		mult_d = mult_q;
		divsel_d = divsel_q;
		halve_d = halve_q;
		if (reg_write && reg_addr == CTRL_ADDR)
		begin
			mult_d = reg_wdata[MULT_LSB +: MULT_W];
			divsel_d = reg_wdata[DIVSEL_LSB +: 2];
			halve_d = reg_wdata[HALVE_BIT];
		end
		// pins reload the programmed multiplier so the ratio holds across release
		if (in_rst)
		begin
			mult_d = pin_multiplier(pin_q[3:2]);
		end
		mult_e = in_rst ? pin_multiplier(pin_q[3:2]) : mult_q; //[R4]
		pdiv_e = in_rst ? 4'h1 : post_divisor(divsel_q); //[R3] [R2]
	end

	logic [31:0] rdata_d;
	logic pclk_d;
	always_comb
	begin
		rdata_d = 32'h0000_0000;
		if (reg_read && reg_addr == CTRL_ADDR)
		begin
			rdata_d[MULT_LSB +: MULT_W] = mult_q;
			rdata_d[DIVSEL_LSB +: 2] = divsel_q;
			rdata_d[HALVE_BIT] = halve_q;
		end
		else if (reg_read && reg_addr == STAT_ADDR)
		begin
			rdata_d[STAT_REL_BIT] = ~core_reset;
			rdata_d[STAT_RST_BIT] = in_rst;
			rdata_d[STAT_VCO_LSB +: MULT_W+1] = vco_ratio;
			rdata_d[STAT_CDIV_LSB +: 5] = core_divisor;
		end
		pclk_d = ~periph_clk_en; //[R6]
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			state_q <= HOLD;
			cnt_q <= '0;
			sync_q <= '0;
			mult_q <= MULT_RST;
			divsel_q <= DIVSEL_RST;
			halve_q <= HALVE_RST;
			reg_rdata <= 32'h0000_0000;
			core_reset <= 1'b1;
			periph_clk_en <= 1'b0;
			eff_multiplier <= MULT_RST;
			eff_post_divisor <= 4'h1;
			vco_ratio <= {MULT_RST, 1'b0};
			core_divisor <= 5'h02;
			loop_input_divisor <= 2'h1;
		end
		else if (clk_en)
		begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			sync_q <= sync_d;
			mult_q <= mult_d;
			divsel_q <= divsel_d;
			halve_q <= halve_d;
			reg_rdata <= rdata_d;
			core_reset <= in_rst;
			periph_clk_en <= pclk_d;
			eff_multiplier <= mult_e;
			eff_post_divisor <= pdiv_e;
			vco_ratio <= {mult_e, 1'b0}; //[R1]
			core_divisor <= {pdiv_e, 1'b0}; //[R2]
			loop_input_divisor <= halve_q ? 2'h2 : 2'h1; //[R5]
		end
	end

	div_forced_a: assert property (@(posedge clk) disable iff (sys_rst) //[R3]
		core_reset |-> eff_post_divisor == 4'h1)
		else $error("post divisor not one during reset");
	mult_pins_a: assert property (@(posedge clk) disable iff (sys_rst) //[R4]
		core_reset && $past(state_q) != RUN && $past(clk_en)
		|-> eff_multiplier == pin_multiplier($past(pin_q[3:2])))
		else $error("reset multiplier not from ratio pins");
	mult_soft_a: assert property (@(posedge clk) disable iff (sys_rst) //[R4]
		!core_reset && $past(clk_en) |-> eff_multiplier == $past(mult_q))
		else $error("run multiplier not from control register");
	vco_ratio_a: assert property (@(posedge clk) disable iff (sys_rst) //[R1]
		$past(clk_en) |-> vco_ratio == {eff_multiplier, 1'b0})
		else $error("oscillator ratio not twice multiplier");
	core_div_a: assert property (@(posedge clk) disable iff (sys_rst) //[R2]
		$past(clk_en) |-> core_divisor == {eff_post_divisor, 1'b0}
		&& (eff_post_divisor == 4'h1 || eff_post_divisor == 4'h2
		|| eff_post_divisor == 4'h4 || eff_post_divisor == 4'h8))
		else $error("core divisor wrong");
	halve_a: assert property (@(posedge clk) disable iff (sys_rst) //[R5]
		clk_en |=> loop_input_divisor == ($past(halve_q) ? 2'h2 : 2'h1))
		else $error("loop input divisor wrong");
	periph_clk_a: assert property (@(posedge clk) disable iff (sys_rst) //[R6]
		!$past(sys_rst) && $past(clk_en) |-> periph_clk_en != $past(periph_clk_en))
		else $error("peripheral clock enable not every second cycle");
	count_done_a: assert property (@(posedge clk) disable iff (sys_rst) //[R10]
		state_q == SYNC && $past(state_q) == COUNT |-> $past(cnt_q) == CNT_W'(REF_DELAY - 1))
		else $error("release delay count wrong");
	sync_hold_a: assert property (@(posedge clk) disable iff (sys_rst) //[R16]
		$fell(core_reset) |-> $past(state_q == SYNC, 2) && $past(state_q == RUN, 1))
		else $error("core reset released without two core cycles");
	// outputs lag sys_rst by one edge, so past-value checks skip that edge
	freeze_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
		!$past(sys_rst) && !$past(clk_en)
		|-> $stable(periph_clk_en) && $stable(core_reset) && $stable(eff_multiplier))
		else $error("state moved while clock enable low");
	rdata_idle_a: assert property (@(posedge clk) disable iff (sys_rst)
		!$past(sys_rst) && $past(clk_en) && !$past(reg_read) |-> reg_rdata == 32'h0000_0000)
		else $error("read data present without a read");
	pin_hold_a: assert property (@(posedge clk) disable iff (sys_rst) //[R10]
		clk_en && !pin_q[1] |=> state_q == HOLD && cnt_q == '0)
		else $error("sequencer not held by reset pin");
	// a late pin edge costs at most one extra reference period, never a longer count
	ref_count_a: assert property (@(posedge clk) disable iff (sys_rst) //[R11]
		cnt_q <= CNT_W'(REF_DELAY))
		else $error("release count ran past its limit");
	sync_len_a: assert property (@(posedge clk) disable iff (sys_rst) //[R16]
		state_q == RUN && $past(state_q) == SYNC |-> $past(sync_q) == 2'(CORE_SYNC_CYCLES - 1))
		else $error("core sync stage too short");
endmodule
